// >>> rtl/pcm_pkg.sv
// Constants and types for the lower port C pin function selector
package pcm_pkg;
	localparam int        PIN_FOUR  = 4;
	localparam int        PIN_THREE = 3;
	localparam int        PIN_RSVD  = 2;
	localparam int        PIN_ONE   = 1;
	localparam int        PIN_ZERO  = 0;
	localparam logic [1:0] IF_WAVEFORM = 2'h2;
	localparam logic [7:0] SEL_RESET   = 8'h00;
	localparam logic [7:0] SEC_RD_MASK = 8'hfb;
	localparam logic [7:0] PAD_RESET   = 8'h00;
	localparam logic       PERIPH_IDLE = 1'b1;
	localparam logic       READY_IDLE  = 1'b0;
	localparam logic       FLAG_RESET  = 1'b0;

	typedef enum logic [1:0] {
		PCM_FN_PORT,
		PCM_FN_PERIPH,
		PCM_FN_WAVE,
		PCM_FN_INVALID
	} pcm_fn_t;
endpackage : pcm_pkg

// >>> rtl/pcm_portc_low_mux.sv
// Pin function selector for port C bits 4, 3, 1 and 0
`timescale 1ns/10ps
module pcm_portc_low_mux
	import pcm_pkg::*;
(
	input  wire logic       ref_clk,
	input  wire logic       rst,
	input  wire logic [7:0] primary_alt_select,
	input  wire logic [7:0] secondary_alt_select,
	input  wire logic [1:0] interface_select,
	input  wire logic       wide_bus_option,
	input  wire logic [7:0] port_out,
	input  wire logic [7:0] port_oe,
	input  wire logic [7:0] pin_in,
	input  wire logic       control_out_one,
	input  wire logic       serial_zero_transmit,
	output logic      [7:0] secondary_readback,
	output logic      [7:0] pin_out,
	output logic      [7:0] pin_oe,
	output logic      [7:0] port_in,
	output logic            timer_zero_input,
	output logic            ext_interrupt_one,
	output logic            serial_zero_receive,
	output logic            ready_in_three,
	output logic            ready_in_one,
	output logic            ready_in_zero,
	output logic            select_invalid
);
	// Bus width option does not alter these low port C pins
	wire       wave_sel = (interface_select == IF_WAVEFORM);
	wire [7:0] per_sel  = primary_alt_select & ~secondary_alt_select;
	wire [7:0] wav_sel  = primary_alt_select & secondary_alt_select & {8{wave_sel}};
	// the bad combination is flagged, pin left undriven
	wire [7:0] bad_sel  = primary_alt_select & secondary_alt_select & {8{~wave_sel}};

	wire [7:0] next_pin_out;
	wire [7:0] next_pin_oe;
	// pin four drives control output one in waveform mode
	assign next_pin_out[PIN_FOUR] = wav_sel[PIN_FOUR] ? control_out_one : port_out[PIN_FOUR];
	assign next_pin_oe[PIN_FOUR]  = wav_sel[PIN_FOUR] | (~per_sel[PIN_FOUR]
		& ~bad_sel[PIN_FOUR] & port_oe[PIN_FOUR]);
	// pin one drives serial transmit when peripheral selected
	assign next_pin_out[PIN_ONE] = per_sel[PIN_ONE] ? serial_zero_transmit : port_out[PIN_ONE];
	assign next_pin_oe[PIN_ONE]  = per_sel[PIN_ONE] | (~wav_sel[PIN_ONE]
		& ~bad_sel[PIN_ONE] & port_oe[PIN_ONE]);
	// input functions: pins three and zero never driven when alternate
	assign next_pin_out[PIN_THREE] = port_out[PIN_THREE];
	assign next_pin_oe[PIN_THREE]  = ~primary_alt_select[PIN_THREE] & port_oe[PIN_THREE];
	assign next_pin_out[PIN_ZERO]  = port_out[PIN_ZERO];
	assign next_pin_oe[PIN_ZERO]   = ~primary_alt_select[PIN_ZERO] & port_oe[PIN_ZERO];
	// Pins outside this block stay plain port pins
	assign next_pin_out[7:5]      = port_out[7:5];
	assign next_pin_oe[7:5]       = port_oe[7:5];
	assign next_pin_out[PIN_RSVD] = port_out[PIN_RSVD];
	assign next_pin_oe[PIN_RSVD]  = port_oe[PIN_RSVD];

	// Idle levels high for peripheral inputs, low for ready inputs, so unrouted ones look inactive
	wire next_timer = per_sel[PIN_FOUR]  ? pin_in[PIN_FOUR]  : 1'b1;
	wire next_ext_interrupt_one  = per_sel[PIN_THREE] ? pin_in[PIN_THREE] : 1'b1;
	wire next_rxd   = per_sel[PIN_ZERO]  ? pin_in[PIN_ZERO]  : 1'b1;
	wire next_ready_in_three  = wav_sel[PIN_THREE] ? pin_in[PIN_THREE] : 1'b0;
	wire next_ready_in_one  = wav_sel[PIN_ONE]   ? pin_in[PIN_ONE]   : 1'b0;
	wire next_ready_in_zero  = wav_sel[PIN_ZERO]  ? pin_in[PIN_ZERO]  : 1'b0;
	wire [7:0] next_readback = secondary_alt_select & SEC_RD_MASK;
	// any pin holding the undefined pair raises the flag
	wire       next_invalid  = |bad_sel;

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			secondary_readback <= SEL_RESET;
		end
		else
		begin
			secondary_readback <= next_readback;
		end
	end

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			select_invalid <= FLAG_RESET;
		end
		else
		begin
			select_invalid <= next_invalid;
		end
	end

	// pad drive registered
	// Released pads at reset so no pin fights the board
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			pin_out <= PAD_RESET;
			pin_oe  <= PAD_RESET;
		end
		else
		begin
			pin_out <= next_pin_out;
			pin_oe  <= next_pin_oe;
		end
	end

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			port_in <= PAD_RESET;
		end
		else
		begin
			port_in <= pin_in;
		end
	end

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			timer_zero_input    <= PERIPH_IDLE;
			ext_interrupt_one   <= PERIPH_IDLE;
			serial_zero_receive <= PERIPH_IDLE;
		end
		else
		begin
			timer_zero_input    <= next_timer;
			ext_interrupt_one   <= next_ext_interrupt_one;
			serial_zero_receive <= next_rxd;
		end
	end

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			ready_in_three <= READY_IDLE;
			ready_in_one   <= READY_IDLE;
			ready_in_zero  <= READY_IDLE;
		end
		else
		begin
			ready_in_three <= next_ready_in_three;
			ready_in_one   <= next_ready_in_one;
			ready_in_zero  <= next_ready_in_zero;
		end
	end

	chk_rsvd_reads_zero: assert property (@(posedge ref_clk) disable iff (rst)
		secondary_readback[PIN_RSVD] == 1'b0) else $error("reserved bit read nonzero");
	chk_pin4_ctl: assert property (@(posedge ref_clk) disable iff (rst)
		wav_sel[PIN_FOUR] |=> pin_oe[PIN_FOUR] && pin_out[PIN_FOUR] == $past(control_out_one))
		else $error("pin four not carrying control out");
	chk_pin4_timer: assert property (@(posedge ref_clk) disable iff (rst)
		per_sel[PIN_FOUR] |=> timer_zero_input == $past(pin_in[PIN_FOUR]) && !pin_oe[PIN_FOUR])
		else $error("timer input wrong");
	chk_pin3_int: assert property (@(posedge ref_clk) disable iff (rst)
		per_sel[PIN_THREE] |=> ext_interrupt_one == $past(pin_in[PIN_THREE]) && !ready_in_three)
		else $error("interrupt input wrong");
	chk_pin3_rdy: assert property (@(posedge ref_clk) disable iff (rst)
		wav_sel[PIN_THREE] |=> ready_in_three == $past(pin_in[PIN_THREE]) && ext_interrupt_one)
		else $error("ready three wrong");
	chk_pin1_txd: assert property (@(posedge ref_clk) disable iff (rst)
		per_sel[PIN_ONE] |=> pin_oe[PIN_ONE] && pin_out[PIN_ONE] == $past(serial_zero_transmit))
		else $error("transmit not driven");
	chk_pin0_func: assert property (@(posedge ref_clk) disable iff (rst)
		primary_alt_select[PIN_ZERO] |=> !pin_oe[PIN_ZERO] && (ready_in_zero ?
		$past(wav_sel[PIN_ZERO]) : 1'b1)) else $error("pin zero function wrong");
	chk_port_plain: assert property (@(posedge ref_clk) disable iff (rst)
		!primary_alt_select[PIN_FOUR] |=> pin_oe[PIN_FOUR] == $past(port_oe[PIN_FOUR]))
		else $error("plain port pin not passed");
	chk_invalid_flag: assert property (@(posedge ref_clk) disable iff (rst)
		(|bad_sel) |=> select_invalid) else $error("invalid select not flagged");
	chk_invalid_clear: assert property (@(posedge ref_clk) disable iff (rst)
		!(|bad_sel) |=> !select_invalid)
		else $error("invalid flag set without cause");
	chk_pin1_rdy: assert property (@(posedge ref_clk) disable iff (rst)
		wav_sel[PIN_ONE] |=> ready_in_one == $past(pin_in[PIN_ONE]) && !pin_oe[PIN_ONE])
		else $error("ready one wrong");
	chk_pin0_rxd: assert property (@(posedge ref_clk) disable iff (rst)
		per_sel[PIN_ZERO] |=> serial_zero_receive == $past(pin_in[PIN_ZERO]) && !ready_in_zero)
		else $error("receive input wrong");
	chk_pin3_float: assert property (@(posedge ref_clk) disable iff (rst)
		primary_alt_select[PIN_THREE] |=> !pin_oe[PIN_THREE])
		else $error("pin three driven while alternate");
	chk_timer_idle: assert property (@(posedge ref_clk) disable iff (rst)
		!per_sel[PIN_FOUR] |=> timer_zero_input)
		else $error("timer input not idle");
	chk_ready_idle: assert property (@(posedge ref_clk) disable iff (rst)
		!wave_sel |=> !ready_in_three && !ready_in_one && !ready_in_zero)
		else $error("ready input active outside waveform mode");
	chk_upper_plain: assert property (@(posedge ref_clk) disable iff (rst)
		1'b1 |=> pin_out[7:5] == $past(port_out[7:5]) && pin_oe[7:5] == $past(port_oe[7:5]))
		else $error("upper pins not plain port");
	chk_readback_copy: assert property (@(posedge ref_clk) disable iff (rst)
		1'b1 |=> secondary_readback[7:3] == $past(secondary_alt_select[7:3]))
		else $error("readback upper bits wrong");
	chk_input_copy: assert property (@(posedge ref_clk) disable iff (rst)
		1'b1 |=> port_in == $past(pin_in))
		else $error("port input copy wrong");

	cov_wave_mode: cover property (@(posedge ref_clk) disable iff (rst) |wav_sel);
	cov_periph:    cover property (@(posedge ref_clk) disable iff (rst) &per_sel[1:0]);
	cov_invalid:   cover property (@(posedge ref_clk) disable iff (rst) |bad_sel);
	cov_ready:     cover property (@(posedge ref_clk) disable iff (rst) ready_in_zero);
	cov_transmit:  cover property (@(posedge ref_clk) disable iff (rst)
		per_sel[PIN_ONE] ##1 pin_oe[PIN_ONE]);
endmodule : pcm_portc_low_mux

// >>> testbench/pcm_pad_model.sv
// Pad model resolving each shared port C pin
`timescale 1ns/10ps
module pcm_pad_model
(
	input  wire logic [7:0] pin_out,
	input  wire logic [7:0] pin_oe,
	input  wire logic [7:0] ext_level,
	output logic      [7:0] pin_in
);
	assign pin_in = (pin_out & pin_oe) | (ext_level & ~pin_oe);
endmodule : pcm_pad_model

// >>> testbench/tb_top.sv
// Self-checking bench for the port C pin selector
`timescale 1ns/10ps
module tb_top;
	logic       ref_clk = 0;
	logic       rst = 1;
	logic [7:0] pri, sec, pout, poe, ext, pin_in, rdbk, pin_out, pin_oe, port_in;
	logic [7:0] eoe, eout, om, pad;
	logic [1:0] ifs;
	logic       ctl, txd, wide, t0, i1, rxd, r3, r1, r0, inv;
	int         n_fail = 0;
	int         num_checks = 0;
	always #25 ref_clk = ~ref_clk;
	pcm_portc_low_mux uut (.ref_clk(ref_clk), .rst(rst), .primary_alt_select(pri),
		.secondary_alt_select(sec), .interface_select(ifs), .wide_bus_option(wide),
		.port_out(pout), .port_oe(poe), .pin_in(pin_in), .control_out_one(ctl),
		.serial_zero_transmit(txd), .secondary_readback(rdbk), .pin_out(pin_out),
		.pin_oe(pin_oe), .port_in(port_in), .timer_zero_input(t0), .ext_interrupt_one(i1),
		.serial_zero_receive(rxd), .ready_in_three(r3), .ready_in_one(r1),
		.ready_in_zero(r0), .select_invalid(inv));
	pcm_pad_model pads (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext), .pin_in(pin_in));
	task chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk
	task stop_test;
		if (n_fail == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : stop_test
	initial
	begin
		#20000;
		n_fail++;
		stop_test;
	end
	initial
	begin
		{pri, sec, pout, poe, ext, ifs, ctl, txd, wide} = '0;
		repeat (2) @(posedge ref_clk);
		rst <= 1'b0;
		for (int p = 0; p < 2; p++)
			for (int m = 0; m < 4; m++)
			begin
				@(posedge ref_clk);
				pri <= (m == 0) ? 8'h00 : 8'h1b;
				sec <= (m < 2) ? 8'h04 : 8'h1f;
				// invalid fields 00, 01, 11 set on purpose
				ifs <= (m == 2) ? 2'h2 : (m == 3 && p == 1) ? 2'h3 : p[1:0];
				pout <= p ? 8'h3c : 8'hc3;
				poe <= p ? 8'hf0 : 8'h0f;
				ext <= p ? 8'h5a : 8'ha5;
				ctl <= p[0];
				txd <= !p[0];
				wide <= p[0];
				@(posedge ref_clk);
				#1;
				eoe = (poe & 8'he4) | (m == 0 ? poe & 8'h1b : m == 1 ? 8'h02 : m == 2 ? 8'h10 : 8'h00);
				eout = (pout & 8'he4) | (m == 0 ? pout & 8'h1b : {3'h0, ctl, 2'h0, txd, 1'h0});
				om = (m == 0) ? 8'hff : 8'he4 | (m == 1 ? 8'h02 : m == 2 ? 8'h10 : 8'h00);
				chk("readback", rdbk, sec & 8'hfb);
				chk("pin_oe", pin_oe, eoe);
				chk("pin_out", pin_out & om, eout & om);
				pad = (eout & eoe) | (ext & ~eoe);
				@(posedge ref_clk);
				#1;
				chk("port_in", port_in, pad);
				chk("periph", {5'h0, t0, i1, rxd}, m == 1 ? {5'h0, pad[4], pad[3], pad[0]} : 8'h07);
				chk("ready", {5'h0, r3, r1, r0}, m == 2 ? {5'h0, pad[3], pad[1], pad[0]} : 8'h00);
				chk("invalid", {7'h0, inv}, {7'h0, m == 3});
			end
		stop_test;
	end
endmodule : tb_top
